// ---- pkg/rtc_defs.svh ----
// rtc_defs.svh: register map, field positions, reset values and counts
// assumes: included by bare name from the package only; modules use its macros without including it
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
// register indexes
`define RTC_IDX_CTRL1      4'h0
`define RTC_IDX_CTRL2      4'h1
`define RTC_IDX_TIME_LO    4'h2
`define RTC_IDX_TIME_HI    4'h8
`define RTC_IDX_ALARM_LO   4'h9
`define RTC_IDX_ALARM_HI   4'hC
`define RTC_IDX_SQW        4'hD
`define RTC_IDX_TMR_CTRL   4'hE
`define RTC_IDX_TMR_VAL    4'hF
// field positions
`define RTC_B_PTEST        7
`define RTC_B_STOP         5
`define RTC_B_STEST        3
`define RTC_B_PULSE        4
`define RTC_B_ALM_FLG      3
`define RTC_B_TMR_FLG      2
`define RTC_B_ALM_IE       1
`define RTC_B_TMR_IE       0
`define RTC_B_EN           7
// reset values
`define RTC_RST_SEL        2'h3
`define RTC_RST_ALARM      32'h80808080
// serial engine
`define RTC_BITS_PER_BYTE  4'h8
`define RTC_DIR_READ       1'b1
// prescaler
`define RTC_DIV_W          15
`define RTC_MASK_4096      15'h0007
`define RTC_MASK_64        15'h01FF
`define RTC_MASK_1         15'h7FFF
`define RTC_SEC_LAST       6'h3B
// pulse widths, in oscillator periods
`define RTC_PW_8192        10'h004
`define RTC_PW_4096        10'h008
`define RTC_PW_128         10'h100
`define RTC_PW_64          10'h200
`define RTC_N_ONE          8'h01
// tick indexes
`define RTC_SRC_4096       2'h0
`define RTC_SRC_64         2'h1
`endif

// ---- pkg/rtc_pkg.sv ----
// rtc_pkg: state encodings and state records
// assumes: rtc_defs.svh on the include path
`include "rtc_defs.svh"
package rtc_pkg;

  typedef enum logic [8:0] {
    RTC_IDLE  = 9'h001,
    RTC_ADDR  = 9'h002,
    RTC_AACK  = 9'h004,
    RTC_PTR   = 9'h008,
    RTC_PACK  = 9'h010,
    RTC_WDATA = 9'h020,
    RTC_WACK  = 9'h040,
    RTC_RDATA = 9'h080,
    RTC_RACK  = 9'h100
  } rtc_bus_e;

  typedef struct packed {
    logic                   osc_q;
    logic                   osc_tick;
    logic [`RTC_DIV_W-1:0]  div;
    logic [5:0]             sec;
    logic [3:0]             tick;
  } rtc_presc_s;

endpackage : rtc_pkg

// ---- pkg/rtc_tick_if.sv ----
// rtc_tick_if: prescaler outputs and divider hold
// assumes: one clock shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface rtc_tick_if;
  logic        hold;
  logic        osc_level;
  logic        osc_tick;
  logic [14:0] div;
  logic [3:0]  tick;
  modport presc (input hold, output osc_level, osc_tick, div, tick);
  modport ctrl  (output hold, input osc_level, osc_tick, div, tick);
endinterface : rtc_tick_if
`default_nettype wire

// ---- rtl/rtc_prescaler.sv ----
// rtc_prescaler: oscillator divider chain and timer source ticks
// assumes: osc_in synchronous to clock_in, far slower than it
`timescale 1ns/100ps
`default_nettype none
module rtc_prescaler
  import rtc_pkg::*;
(
  // clock and reset
  input  wire logic   clock_in,
  input  wire logic   resetn_in,
  // oscillator
  input  wire logic   osc_in,
  // ticks
  rtc_tick_if.presc   tk
);

  rtc_presc_s r;
  rtc_presc_s n;

  always_comb begin
    n          = r;
    n.osc_q    = osc_in;
    n.osc_tick = ~r.osc_q & osc_in;
    n.tick     = 4'h0;
    if (tk.hold) begin
      n.div = '0;
      n.sec = 6'h00;
    end else if (n.osc_tick) begin
      n.div     = r.div + 15'h0001;
      n.tick[0] = (r.div & `RTC_MASK_4096) == `RTC_MASK_4096;
      n.tick[1] = (r.div & `RTC_MASK_64) == `RTC_MASK_64;
      n.tick[2] = r.div == `RTC_MASK_1;
      if (n.tick[2]) begin
        n.sec     = (r.sec == `RTC_SEC_LAST) ? 6'h00 : r.sec + 6'h01;
        n.tick[3] = r.sec == `RTC_SEC_LAST;
      end
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tk.osc_level = r.osc_q;
  assign tk.osc_tick  = r.osc_tick;
  assign tk.div       = r.div;
  assign tk.tick      = r.tick;

endmodule : rtc_prescaler
`default_nettype wire

// ---- rtl/rtc_ctrl_top.sv ----
// rtc_ctrl_top: control registers, timer, interrupt, square wave, serial target
// assumes: scl_in, sda_in, osc_in synchronous to clock_in; open-drain pins resolved outside
//
// Function
// - primary test-enable bit at 1 enters test mode, 0 normal.
// - divider-stop bit at 1 in test mode holds prescaler dividers at zero.
// - secondary test-enable bit at 1 activates test mode, 0 normal.
// - pulse-select 0: set timer flag holds interrupt low while set.
// - pulse-select 1: interrupt pulses on timer event, width from source and N.
// - timer flag and interrupt output assert in the same cycle.
// - countdown value zero keeps timer stopped, no events.
// - alarm flag set by alarm; software may only clear it.
// - timer flag set by timer; software may only clear it.
// - alarm interrupt enable gates alarm flag onto interrupt output.
// - timer interrupt enable gates timer events onto interrupt output.
// - square-wave enable drives the clock output at the selected frequency.
// - frequency codes: 32.768 kHz, 8.192 kHz, 4.096 kHz, 1 Hz.
// - timer clock enable feeds the selected source to the countdown.
// - timer source codes: 4096 Hz, 64 Hz, 1 Hz, 1/60 Hz.
// - in writes every received byte, address included, is acknowledged low.
// - every byte moves most significant bit first.
// - first byte after START matched against seven-bit address plus direction.
// - byte after write address loads pointer; later bytes write selected register.
// - reads start at the current pointer, kept from earlier transfers.
// - repeated START ends the transfer and expects a new address byte.
// - pointer advances after every data byte, read or written, until STOP.
// - START copies running time counters into a shadow set for reads.
// - reset: all bits zero except square-wave enable, timer source select, secondary test, alarm disables.
`timescale 1ns/100ps
`default_nettype none
module rtc_ctrl_top
  import rtc_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = 7'h2A  // arbitrary value
)
(
  // clock and reset
  input  wire logic         clock_in,
  input  wire logic         resetn_in,
  // serial bus
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output logic              sda_oe_n_out,
  // oscillator
  input  wire logic         osc_in,
  // timekeeping and alarm side
  input  wire logic [55:0]  time_regs_in,
  input  wire logic         alarm_match_in,
  output logic              time_wr_out,
  output logic [2:0]        time_wr_index_out,
  output logic [7:0]        time_wr_data_out,
  output logic [31:0]       alarm_regs_out,
  // pins and mode levels
  output logic              int_oe_n_out,
  output logic              square_wave_out_oe_n_out,
  output logic              primary_test_enable_out,
  output logic              secondary_test_enable_out
);

  typedef struct packed {
    rtc_bus_e     st;
    logic         scl_q;
    logic         sda_q;
    logic [3:0]   cnt;
    logic [7:0]   shift;
    logic         dir;
    logic [3:0]   ptr;
    logic         sda_oe_n;
    logic         primary_test_enable;
    logic         div_stop;
    logic         secondary_test_enable;
    logic         interrupt_pulse_select;
    logic         alarm_event_flag;
    logic         timer_event_flag;
    logic         alarm_interrupt_enable;
    logic         timer_interrupt_enable;
    logic         square_wave_enable;
    logic [1:0]   square_wave_freq_sel;
    logic         timer_clock_enable;
    logic [1:0]   timer_source_sel;
    logic [7:0]   tmr_n;
    logic [7:0]   tmr_cnt;
    logic [9:0]   pulse_cnt;
    logic [55:0]  shadow;
    logic [31:0]  alarm;
    logic         int_n;
    logic         sq_oe_n;
    logic         time_wr;
    logic [2:0]   time_idx;
    logic [7:0]   time_data;
  } rtc_top_s;

  rtc_top_s   r;
  rtc_top_s   n;
  rtc_tick_if tk ();

  logic       start_c;
  logic       stop_c;
  logic       rise_c;
  logic       fall_c;

  ////////////////////////////////////////////////////////////////////////////////
  // prescaler
  rtc_prescaler u_presc (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .osc_in    (osc_in),
    .tk        (tk)
  );

  assign tk.hold = r.primary_test_enable & r.div_stop;

  ////////////////////////////////////////////////////////////////////////////////
  // bus conditions
  assign start_c = r.scl_q & scl_in & r.sda_q & ~sda_in;
  assign stop_c  = r.scl_q & scl_in & ~r.sda_q & sda_in;
  assign rise_c  = ~r.scl_q & scl_in;
  assign fall_c  = r.scl_q & ~scl_in;

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [7:0] rd;
    logic [7:0] d;
    logic       wr_en;
    logic       evt;
    logic       sq_lvl;
    logic [9:0] pw;
    logic [1:0] aidx;
    rd     = 8'h00;
    d      = r.shift;
    wr_en  = 1'b0;
    evt    = 1'b0;
    sq_lvl = 1'b0;
    pw     = `RTC_PW_64;
    aidx   = r.ptr[1:0] - 2'h1;
    n      = r;
    n.scl_q   = scl_in;
    n.sda_q   = sda_in;
    n.time_wr = 1'b0;

    // read mux
    case (r.ptr)
      `RTC_IDX_CTRL1: begin
        rd[`RTC_B_PTEST] = r.primary_test_enable;
        rd[`RTC_B_STOP]  = r.div_stop;
        rd[`RTC_B_STEST] = r.secondary_test_enable;
      end
      `RTC_IDX_CTRL2: begin
        rd[`RTC_B_PULSE]   = r.interrupt_pulse_select;
        rd[`RTC_B_ALM_FLG] = r.alarm_event_flag;
        rd[`RTC_B_TMR_FLG] = r.timer_event_flag;
        rd[`RTC_B_ALM_IE]  = r.alarm_interrupt_enable;
        rd[`RTC_B_TMR_IE]  = r.timer_interrupt_enable;
      end
      `RTC_IDX_SQW: begin
        rd[`RTC_B_EN] = r.square_wave_enable;
        rd[1:0]       = r.square_wave_freq_sel;
      end
      `RTC_IDX_TMR_CTRL: begin
        rd[`RTC_B_EN] = r.timer_clock_enable;
        rd[1:0]       = r.timer_source_sel;
      end
      `RTC_IDX_TMR_VAL: begin
        rd = r.tmr_cnt;
      end
      default: begin
        if (r.ptr >= `RTC_IDX_ALARM_LO) begin
          rd = r.alarm[{aidx, 3'h0} +: 8];
        end else begin
          rd = r.shadow[{r.ptr[2:0] - 3'h2, 3'h0} +: 8];
        end
      end
    endcase

    // serial target
    if (start_c) begin
      n.st       = RTC_ADDR;
      n.cnt      = 4'h0;
      n.sda_oe_n = 1'b1;
      n.shadow   = time_regs_in;
    end else if (stop_c) begin
      n.st       = RTC_IDLE;
      n.sda_oe_n = 1'b1;
    end else if (rise_c) begin
      case (r.st)
        RTC_ADDR, RTC_PTR, RTC_WDATA: begin
          n.shift = {r.shift[6:0], sda_in};
          n.cnt   = r.cnt + 4'h1;
        end
        RTC_RDATA: begin
          n.cnt = r.cnt + 4'h1;
        end
        RTC_RACK: begin
          if (sda_in) begin
            n.st = RTC_IDLE;
          end
        end
        default: begin
          n.st = r.st;
        end
      endcase
    end else if (fall_c) begin
      case (r.st)
        RTC_ADDR: begin
          if (r.cnt == `RTC_BITS_PER_BYTE) begin
            if (r.shift[7:1] == TARGET_ADDR) begin
              n.sda_oe_n = 1'b0;
              n.dir      = r.shift[0];
              n.st       = RTC_AACK;
            end else begin
              n.st = RTC_IDLE;
            end
          end
        end
        RTC_AACK: begin
          n.cnt = 4'h0;
          if (r.dir == `RTC_DIR_READ) begin
            n.shift    = rd;
            n.sda_oe_n = rd[7];
            n.st       = RTC_RDATA;
          end else begin
            n.sda_oe_n = 1'b1;
            n.st       = RTC_PTR;
          end
        end
        RTC_PTR: begin
          if (r.cnt == `RTC_BITS_PER_BYTE) begin
            n.ptr      = r.shift[3:0];
            n.sda_oe_n = 1'b0;
            n.st       = RTC_PACK;
          end
        end
        RTC_PACK, RTC_WACK: begin
          n.sda_oe_n = 1'b1;
          n.cnt      = 4'h0;
          n.st       = RTC_WDATA;
        end
        RTC_WDATA: begin
          if (r.cnt == `RTC_BITS_PER_BYTE) begin
            wr_en      = 1'b1;
            n.ptr      = r.ptr + 4'h1;
            n.sda_oe_n = 1'b0;
            n.st       = RTC_WACK;
          end
        end
        RTC_RDATA: begin
          if (r.cnt == `RTC_BITS_PER_BYTE) begin
            n.sda_oe_n = 1'b1;
            n.ptr      = r.ptr + 4'h1;
            n.st       = RTC_RACK;
          end else begin
            n.shift    = {r.shift[6:0], 1'b0};
            n.sda_oe_n = r.shift[6];
          end
        end
        RTC_RACK: begin
          n.shift    = rd;
          n.sda_oe_n = rd[7];
          n.cnt      = 4'h0;
          n.st       = RTC_RDATA;
        end
        default: begin
          n.sda_oe_n = 1'b1;
        end
      endcase
    end

    // countdown timer
    if (r.timer_clock_enable && tk.tick[r.timer_source_sel]) begin
      if (r.tmr_n != 8'h00) begin
        if (r.tmr_cnt <= `RTC_N_ONE) begin
          evt       = 1'b1;
          n.tmr_cnt = r.tmr_n;
        end else begin
          n.tmr_cnt = r.tmr_cnt - 8'h01;
        end
      end
    end

    // register writes
    if (wr_en) begin
      case (r.ptr)
        `RTC_IDX_CTRL1: begin
          n.primary_test_enable   = d[`RTC_B_PTEST];
          n.div_stop              = d[`RTC_B_STOP];
          n.secondary_test_enable = d[`RTC_B_STEST];
        end
        `RTC_IDX_CTRL2: begin
          n.interrupt_pulse_select = d[`RTC_B_PULSE];
          n.alarm_event_flag       = r.alarm_event_flag & d[`RTC_B_ALM_FLG];
          n.timer_event_flag       = r.timer_event_flag & d[`RTC_B_TMR_FLG];
          n.alarm_interrupt_enable = d[`RTC_B_ALM_IE];
          n.timer_interrupt_enable = d[`RTC_B_TMR_IE];
        end
        `RTC_IDX_SQW: begin
          n.square_wave_enable   = d[`RTC_B_EN];
          n.square_wave_freq_sel = d[1:0];
        end
        `RTC_IDX_TMR_CTRL: begin
          n.timer_clock_enable = d[`RTC_B_EN];
          n.timer_source_sel   = d[1:0];
        end
        `RTC_IDX_TMR_VAL: begin
          n.tmr_n   = d;
          n.tmr_cnt = d;
        end
        default: begin
          if (r.ptr >= `RTC_IDX_ALARM_LO) begin
            n.alarm[{aidx, 3'h0} +: 8] = d;
          end else if (r.ptr >= `RTC_IDX_TIME_LO) begin
            n.time_wr   = 1'b1;
            n.time_idx  = r.ptr[2:0] - 3'h2;
            n.time_data = d;
          end
        end
      endcase
    end

    // flags: a set wins over a clear
    if (alarm_match_in) begin
      n.alarm_event_flag = 1'b1;
    end
    if (evt) begin
      n.timer_event_flag = 1'b1;
    end

    // pulse width
    case (r.timer_source_sel)
      `RTC_SRC_4096: pw = (r.tmr_n == `RTC_N_ONE) ? `RTC_PW_8192 : `RTC_PW_4096;
      `RTC_SRC_64:   pw = (r.tmr_n == `RTC_N_ONE) ? `RTC_PW_128 : `RTC_PW_64;
      default:       pw = `RTC_PW_64;
    endcase
    if (evt && r.interrupt_pulse_select) begin
      n.pulse_cnt = pw;
    end else if (tk.osc_tick && r.pulse_cnt != 10'h000) begin
      n.pulse_cnt = r.pulse_cnt - 10'h001;
    end

    // interrupt pin, from next-state flags
    n.int_n = ~(((n.interrupt_pulse_select ? (n.pulse_cnt != 10'h000)
                                           : n.timer_event_flag)
                 & n.timer_interrupt_enable)
                | (n.alarm_event_flag & n.alarm_interrupt_enable));

    // square wave
    case (r.square_wave_freq_sel)
      2'h0:    sq_lvl = tk.osc_level;
      2'h1:    sq_lvl = tk.div[1];
      2'h2:    sq_lvl = tk.div[2];
      default: sq_lvl = tk.div[14];
    endcase
    n.sq_oe_n = ~r.square_wave_enable | sq_lvl;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r                       <= '0;
      r.st                    <= RTC_IDLE;
      r.scl_q                 <= 1'b1;
      r.sda_q                 <= 1'b1;
      r.sda_oe_n              <= 1'b1;
      r.secondary_test_enable <= 1'b1;
      r.square_wave_enable    <= 1'b1;
      r.timer_source_sel      <= `RTC_RST_SEL;
      r.alarm                 <= `RTC_RST_ALARM;
      r.int_n                 <= 1'b1;
      r.sq_oe_n               <= 1'b1;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign sda_oe_n_out              = r.sda_oe_n;
  assign time_wr_out               = r.time_wr;
  assign time_wr_index_out         = r.time_idx;
  assign time_wr_data_out          = r.time_data;
  assign alarm_regs_out            = r.alarm;
  assign int_oe_n_out              = r.int_n;
  assign square_wave_out_oe_n_out  = r.sq_oe_n;
  assign primary_test_enable_out   = r.primary_test_enable;
  assign secondary_test_enable_out = r.secondary_test_enable;

endmodule : rtc_ctrl_top
`default_nettype wire

// ---- bench/rtc_ctrl_chk.sv ----
// rtc_ctrl_chk: pin-level checks on rtc_ctrl_top
// assumes: bound to rtc_ctrl_top, single clock domain
`timescale 1ns/100ps
`default_nettype none
module rtc_ctrl_chk (
  // clock and reset
  input wire logic        clock_in,
  input wire logic        resetn_in,
  // serial bus
  input wire logic        scl_in,
  input wire logic        sda_oe_n_out,
  // pins and state
  input wire logic        osc_in,
  input wire logic        time_wr_out,
  input wire logic [2:0]  time_wr_index_out,
  input wire logic [31:0] alarm_regs_out,
  input wire logic        square_wave_out_oe_n_out,
  input wire logic        primary_test_enable_out,
  input wire logic        secondary_test_enable_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  ////////////////////////////////////////
  a_ack_holds_high: assert property (!sda_oe_n_out && scl_in && $past(scl_in) && $past(scl_in, 2) |=> !sda_oe_n_out)
    else $error("sda drive dropped while scl high");
  a_wr_one_cycle: assert property (time_wr_out |=> !time_wr_out)
    else $error("time write pulse too long");
  a_wr_index_map: assert property (time_wr_out |-> time_wr_index_out <= 3'h6)
    else $error("time write index out of range");
  a_wr_after_ack: assert property (time_wr_out |-> !sda_oe_n_out && $past(sda_oe_n_out))
    else $error("time write without ack");
  a_ptest_by_write: assert property ($changed(primary_test_enable_out) |-> !sda_oe_n_out)
    else $error("test level moved outside a write");
  a_stest_by_write: assert property ($changed(secondary_test_enable_out) |-> !sda_oe_n_out)
    else $error("second test level moved outside a write");
  a_alarm_by_write: assert property (!$stable(alarm_regs_out) |-> !sda_oe_n_out)
    else $error("alarm regs moved outside a write");
  a_sqw_after_osc: assert property ($changed(square_wave_out_oe_n_out) |-> ($past(osc_in) != $past(osc_in, 2))
    || ($past(osc_in, 2) != $past(osc_in, 3)) || ($past(osc_in, 3) != $past(osc_in, 4)) || !sda_oe_n_out
    || !$past(resetn_in, 2))
    else $error("square wave moved without oscillator edge");
endmodule : rtc_ctrl_chk
bind rtc_ctrl_top rtc_ctrl_chk chk_u (
  .clock_in(clock_in), .resetn_in(resetn_in), .scl_in(scl_in), .sda_oe_n_out(sda_oe_n_out),
  .osc_in(osc_in), .time_wr_out(time_wr_out), .time_wr_index_out(time_wr_index_out),
  .alarm_regs_out(alarm_regs_out), .square_wave_out_oe_n_out(square_wave_out_oe_n_out),
  .primary_test_enable_out(primary_test_enable_out), .secondary_test_enable_out(secondary_test_enable_out));
`default_nettype wire

// ---- bench/rtc_bus_host.sv ----
// rtc_bus_host: two-wire bus controller model
// assumes: sda_in is the resolved wire with pull-up
`timescale 1ns/100ps
`default_nettype none
module rtc_bus_host (
  // clock
  input  wire logic clock_in,
  // bus
  input  wire logic sda_in,
  output var logic  scl_out,
  output var logic  sda_oe_n_out
);
  localparam int H = 4;
  initial begin
    scl_out = 1'b1;
    sda_oe_n_out = 1'b1;
  end
  task automatic hw();
    repeat (H) @(negedge clock_in);
  endtask : hw
  ////////////////////////////////////////
  // start or repeated start
  task automatic start_c();
    sda_oe_n_out = 1'b1;
    hw();
    scl_out = 1'b1;
    hw();
    sda_oe_n_out = 1'b0;
    hw();
    scl_out = 1'b0;
    hw();
  endtask : start_c
  task automatic stop_c();
    sda_oe_n_out = 1'b0;
    hw();
    scl_out = 1'b1;
    hw();
    sda_oe_n_out = 1'b1;
    hw();
  endtask : stop_c
  // data moves only while scl low
  task automatic bit_x(input logic b, output logic r);
    sda_oe_n_out = b;
    hw();
    scl_out = 1'b1;
    hw();
    r = sda_in;
    scl_out = 1'b0;
    hw();
  endtask : bit_x
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(a, ak);
  endtask : xfer
endmodule : rtc_bus_host
`default_nettype wire

// ---- bench/tb.sv ----
// tb: self-checking bench for rtc_ctrl_top
// assumes: bus host model drives scl and shares sda with pull-up
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [6:0] TA = 7'h2A;
  logic        clock_in, resetn_in, osc_in, alarm_match_in, scl, d_sda_n, h_sda_n;
  logic        time_wr, int_oe_n, sq_oe_n, pt, st, ak;
  logic [55:0] time_regs_in;
  logic [2:0]  time_wr_index, wi;
  logic [7:0]  time_wr_data, wd, q;
  logic [31:0] alarm_regs;
  wire logic   sda_w;
  int          failures = 0;
  int          checks_done = 0;
  int          cnt;
  assign sda_w = d_sda_n & h_sda_n;
  rtc_ctrl_top #(.TARGET_ADDR(TA)) dut_u (
    .clock_in(clock_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda_w), .sda_oe_n_out(d_sda_n),
    .osc_in(osc_in), .time_regs_in(time_regs_in), .alarm_match_in(alarm_match_in), .time_wr_out(time_wr),
    .time_wr_index_out(time_wr_index), .time_wr_data_out(time_wr_data), .alarm_regs_out(alarm_regs),
    .int_oe_n_out(int_oe_n), .square_wave_out_oe_n_out(sq_oe_n), .primary_test_enable_out(pt),
    .secondary_test_enable_out(st));
  rtc_bus_host host_u (.clock_in(clock_in), .sda_in(sda_w), .scl_out(scl), .sda_oe_n_out(h_sda_n));
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  initial begin
    osc_in = 1'b0;
    forever begin
      repeat (8) @(negedge clock_in);
      osc_in = ~osc_in;
    end
  end
  always @(posedge clock_in) if (time_wr === 1'b1) begin
    wi <= time_wr_index;
    wd <= time_wr_data;
  end
  ////////////////////////////////////////
  task automatic final_report();
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic send(input logic [7:0] d);
    host_u.xfer(d, 1'b1, q, ak);
    chk("byte ack", ak, 1'b0);
  endtask : send
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host_u.start_c();
    send({TA, 1'b0});
    send(p);
    send(d);
    host_u.stop_c();
  endtask : wr
  task automatic rd(input logic [7:0] p, input int n, input logic [31:0] e);
    host_u.start_c();
    send({TA, 1'b0});
    send(p);
    host_u.start_c();
    send({TA, 1'b1});
    for (int i = n - 1; i >= 0; i--) begin
      host_u.xfer(8'hFF, i == 0, q, ak);
      chk("read byte", q, e[8*i +: 8]);
    end
    host_u.stop_c();
  endtask : rd
  task automatic cnt_sq(output int c);
    logic p;
    c = 0;
    p = sq_oe_n;
    repeat (128) begin
      @(negedge clock_in);
      c += (sq_oe_n !== p);
      p = sq_oe_n;
    end
  endtask : cnt_sq
  task automatic wait_int();
    int n;
    n = 0;
    while (int_oe_n !== 1'b0 && n < 1000) begin
      @(negedge clock_in);
      n++;
    end
    chk("int wait", n < 1000, 1'b1);
    if (n >= 1000) final_report();
  endtask : wait_int
  ////////////////////////////////////////
  task automatic t_reset();
    chk("ptest", pt, 1'b0);
    chk("stest", st, 1'b1);
    chk("alarm regs", alarm_regs, 32'h80808080);
    rd(8'h00, 2, 32'h0800);
    rd(8'h0D, 4, 32'h80030008);
    host_u.start_c();
    send({TA, 1'b1});
    host_u.xfer(8'hFF, 1'b1, q, ak);
    chk("kept pointer", q, 8'h00);
    host_u.stop_c();
    host_u.start_c();
    host_u.xfer({TA ^ 7'h01, 1'b0}, 1'b1, q, ak);
    chk("foreign ack", ak, 1'b1);
    host_u.stop_c();
  endtask : t_reset
  task automatic t_sqw();
    for (int k = 0; k < 4; k++) begin
      wr(8'h0D, 8'h80 | k[7:0]);
      cnt_sq(cnt);
      chk("sq toggles", cnt, k == 0 ? 16 : k == 1 ? 4 : k == 2 ? 2 : 0);
    end
    wr(8'h0D, 8'h01);
    cnt_sq(cnt);
    chk("sq off", {cnt[30:0], sq_oe_n}, 32'h1);
  endtask : t_sqw
  task automatic t_test();
    wr(8'h0D, 8'h81);
    wr(8'h00, 8'hA8);
    chk("test on", {pt, st}, 2'b11);
    rd(8'h00, 1, 32'hA8);
    cnt_sq(cnt);
    chk("held sq", cnt, 0);
    wr(8'h00, 8'h00);
    chk("test off", {pt, st}, 2'b00);
    cnt_sq(cnt);
    chk("run sq", cnt, 4);
  endtask : t_test
  task automatic t_time();
    host_u.start_c();
    send({TA, 1'b0});
    send(8'h08);
    send(8'h5A);
    send(8'h33);
    host_u.stop_c();
    chk("wr index", wi, 3'h6);
    chk("wr data", wd, 8'h5A);
    chk("alarm byte", alarm_regs, 32'h80808033);
    time_regs_in[15:8] = 8'h45;
    host_u.start_c();
    send({TA, 1'b0});
    send(8'h03);
    host_u.start_c();
    send({TA, 1'b1});
    time_regs_in[15:8] = 8'h12;
    host_u.xfer(8'hFF, 1'b1, q, ak);
    chk("shadow", q, 8'h45);
    host_u.stop_c();
  endtask : t_time
  task automatic t_alarm();
    wr(8'h01, 8'h00);
    alarm_match_in = 1'b1;
    @(negedge clock_in);
    alarm_match_in = 1'b0;
    repeat (4) @(negedge clock_in);
    chk("masked int", int_oe_n, 1'b1);
    rd(8'h01, 1, 32'h08);
    wr(8'h01, 8'h0A);
    chk("alarm int", int_oe_n, 1'b0);
    wr(8'h01, 8'h02);
    wr(8'h01, 8'h0A);
    chk("released int", int_oe_n, 1'b1);
    rd(8'h01, 1, 32'h02);
  endtask : t_alarm
  task automatic t_timer();
    wr(8'h0E, 8'h80);
    wr(8'h0F, 8'h00);
    wr(8'h01, 8'h01);
    repeat (600) @(negedge clock_in);
    chk("stopped timer", int_oe_n, 1'b1);
    wr(8'h0F, 8'h02);
    wait_int();
    wr(8'h0E, 8'h03);
    rd(8'h01, 1, 32'h05);
    chk("level int", int_oe_n, 1'b0);
    wr(8'h01, 8'h01);
    repeat (600) @(negedge clock_in);
    chk("cleared int", int_oe_n, 1'b1);
    wr(8'h01, 8'h11);
    wr(8'h0F, 8'h02);
    wr(8'h0E, 8'h80);
    wait_int();
    cnt = 0;
    while (int_oe_n === 1'b0 && cnt < 300) begin
      @(negedge clock_in);
      cnt++;
    end
    chk("pulse width", cnt >= 120 && cnt <= 136, 1'b1);
    if (cnt >= 300) final_report();
  endtask : t_timer
  ////////////////////////////////////////
  initial begin
    resetn_in = 1'b0;
    alarm_match_in = 1'b0;
    time_regs_in = 56'h0;
    repeat (2) @(negedge clock_in);
    resetn_in = 1'b1;
    repeat (2) @(negedge clock_in);
    t_reset();
    t_sqw();
    t_test();
    t_time();
    t_alarm();
    t_timer();
    final_report();
  end
endmodule : tb
`default_nettype wire
